// >>> design/drs_defines.svh
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// =====================================================================
// register offsets (byte addresses)
`define DRS_OFS_MODE      8'h00
`define DRS_OFS_SUPPLY    8'h04
`define DRS_OFS_RESET     8'h08
`define DRS_OFS_TRIM      8'h0c
`define DRS_OFS_TRIMPIN   8'h10

// =====================================================================
// field positions
`define DRS_RST_POL_BIT   16
`define DRS_TRIM_GO_BIT   0
`define DRS_TRIM_LEN_BIT  1
`define DRS_TRIM_BUSY_BIT 2
`define DRS_VPP_LSB       16

// =====================================================================
// reset values
`define DRS_MODE_RST      32'h0000_0000
`define DRS_SUPPLY_RST    16'h0000
`define DRS_RESET_RST     16'h0000
`define DRS_TRIMPIN_RST   16'h0000

// =====================================================================
// timing
`define DRS_CLK_HZ        10000000
`define DRS_TRIM_SHORT_MS 300
`define DRS_TRIM_LONG_MS  500

`endif

// >>> design/drs_pkg.sv
package drs_pkg;
	// per-channel routing mode, gray along normal -> trim -> loopback
	typedef enum logic [1:0] {
		DRS_MODE_NORMAL = 2'h0,
		DRS_MODE_TRIM   = 2'h1,
		DRS_MODE_LOOP   = 2'h3,
		DRS_MODE_RSVD   = 2'h2
	} drs_mode_t;

	typedef enum logic {
		DRS_TMR_IDLE = 1'h0,
		DRS_TMR_RUN  = 1'h1
	} drs_tmr_state_t;
endpackage : drs_pkg

// >>> design/drs_trim_if.sv
`timescale 1ns/1ps
// trim pulse request and pulse level between the switch and its timer
interface drs_trim_if;
	logic start;
	logic longSel;
	logic pulse;
	logic busy;

	modport ctrl  (output start, output longSel, input pulse, input busy);
	modport timer (input start, input longSel, output pulse, output busy);
endinterface : drs_trim_if

// >>> design/drs_trim_pulse_timer.sv
`timescale 1ns/1ps
module drs_trim_pulse_timer #(
	parameter logic [22:0] SHORT_CYC = 23'h0,
	parameter logic [22:0] LONG_CYC  = 23'h0
) (
	input  wire logic clk,
	input  wire logic srst,
	drs_trim_if.timer trim
);
	drs_pkg::drs_tmr_state_t state;
	logic [22:0]             remain;

	// =====================================================================
	// single shot: a start while running is ignored so the pulse stays exact
	always_ff @(posedge clk) begin
		if (srst) begin
			state  <= drs_pkg::DRS_TMR_IDLE;
			remain <= 23'h0;
		end else begin
			unique case (state)
				drs_pkg::DRS_TMR_IDLE: begin
					if (trim.start) begin
						state  <= drs_pkg::DRS_TMR_RUN;
						remain <= trim.longSel ? LONG_CYC : SHORT_CYC;
					end
				end
				drs_pkg::DRS_TMR_RUN: begin
					if (remain == 23'h1)
						state <= drs_pkg::DRS_TMR_IDLE;
					remain <= remain - 23'h1;
				end
			endcase
		end
	end

	// pulse high for exactly the loaded count of cycles
	assign trim.pulse = (state == drs_pkg::DRS_TMR_RUN);
	assign trim.busy  = (state == drs_pkg::DRS_TMR_RUN);
endmodule : drs_trim_pulse_timer

// >>> design/drs_uart_route_switch.sv
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "drs_defines.svh"
module drs_uart_route_switch #(
	parameter int unsigned TRIM_SHORT_CYC = `DRS_TRIM_SHORT_MS * (`DRS_CLK_HZ / 1000),
	parameter int unsigned TRIM_LONG_CYC  = `DRS_TRIM_LONG_MS * (`DRS_CLK_HZ / 1000)
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	input  wire logic [15:0] hostTx,
	output logic      [15:0] hostRx,
	input  wire logic [15:0] targetTx,
	output logic      [15:0] targetRx,
	output logic      [15:0] targetRxOe_n,
	output logic      [15:0] targetTxOe_n,
	output logic      [15:0] calPulse,
	output logic      [15:0] vbatEn,
	output logic      [15:0] vppEn,
	output logic      [15:0] targetRst
);
	// =====================================================================
	// registers
	logic [31:0] modeReg;
	logic [15:0] vbatReg;
	logic [15:0] vppReg;
	logic [15:0] rstReg;
	logic        rstActiveHigh;
	logic        trimLong;
	logic [15:0] trimPinReg;
	drs_trim_if  trimBus ();

	// =====================================================================
	// register writes and srst: the only ways any switch position changes
	// one process per register offset so each concern resets and loads on its own
	always_ff @(posedge clk) begin
		if (srst) begin
			modeReg <= `DRS_MODE_RST;
		end else if (regWr && (regAddr == `DRS_OFS_MODE)) begin
			modeReg <= regWdata;
		end
	end

	// battery supply and programming supply requests
	always_ff @(posedge clk) begin
		if (srst) begin
			vbatReg <= `DRS_SUPPLY_RST;
			vppReg  <= `DRS_SUPPLY_RST;
		end else if (regWr && (regAddr == `DRS_OFS_SUPPLY)) begin
			vbatReg <= regWdata[15:0];
			vppReg  <= regWdata[`DRS_VPP_LSB +: 16];
		end
	end

	// reset requests and the one polarity bit shared by all targets
	always_ff @(posedge clk) begin
		if (srst) begin
			rstReg        <= `DRS_RESET_RST;
			rstActiveHigh <= 1'b0;
		end else if (regWr && (regAddr == `DRS_OFS_RESET)) begin
			rstReg        <= regWdata[15:0];
			rstActiveHigh <= regWdata[`DRS_RST_POL_BIT];
		end
	end

	// length kept for readback; a go refused while busy still updates it
	always_ff @(posedge clk) begin
		if (srst) begin
			trimLong <= 1'b0;
		end else if (regWr && (regAddr == `DRS_OFS_TRIM)) begin
			trimLong <= regWdata[`DRS_TRIM_LEN_BIT];
		end
	end

	// pulse pin choice per channel: receive line or dedicated output
	always_ff @(posedge clk) begin
		if (srst) begin
			trimPinReg <= `DRS_TRIMPIN_RST;
		end else if (regWr && (regAddr == `DRS_OFS_TRIMPIN)) begin
			trimPinReg <= regWdata[15:0];
		end
	end

	// start pulse for the timer; length chosen in the same write
	assign trimBus.start   = regWr && (regAddr == `DRS_OFS_TRIM) && regWdata[`DRS_TRIM_GO_BIT];
	assign trimBus.longSel = regWdata[`DRS_TRIM_LEN_BIT];

	drs_trim_pulse_timer #(
		.SHORT_CYC (TRIM_SHORT_CYC[22:0]),
		.LONG_CYC  (TRIM_LONG_CYC[22:0])
	) u_trim_pulse_timer (
		.clk  (clk),
		.srst (srst),
		.trim (trimBus.timer)
	);

	// =====================================================================
	// read port, data stands one cycle after the strobe; unmapped reads 0
	always_ff @(posedge clk) begin
		if (srst) begin
			regRdata <= 32'h0;
		end else if (regRd) begin
			unique case (regAddr)
				`DRS_OFS_MODE:    regRdata <= modeReg;
				`DRS_OFS_SUPPLY:  regRdata <= {vppReg, vbatReg};
				`DRS_OFS_RESET:   regRdata <= {15'h0, rstActiveHigh, rstReg};
				`DRS_OFS_TRIM:    regRdata <= {29'h0, trimBus.busy, trimLong, 1'b0};
				`DRS_OFS_TRIMPIN: regRdata <= {16'h0, trimPinReg};
				default:          regRdata <= 32'h0;
			endcase
		end else begin
			regRdata <= 32'h0;
		end
	end

	// =====================================================================
	// two-flop synchronisers on the asynchronous UART pins
	logic [15:0] hostTxMeta;
	logic [15:0] hostTxSync;
	logic [15:0] targetTxMeta;
	logic [15:0] targetTxSync;

	always_ff @(posedge clk) begin
		if (srst) begin
			hostTxMeta   <= 16'hffff;
			hostTxSync   <= 16'hffff;
			targetTxMeta <= 16'hffff;
			targetTxSync <= 16'hffff;
		end else begin
			hostTxMeta   <= hostTx;
			hostTxSync   <= hostTxMeta;
			targetTxMeta <= targetTx;
			targetTxSync <= targetTxMeta;
		end
	end

	// =====================================================================
	// per-channel routing; every output registered so a mode change
	// never shows a combinational glitch on a target pin
	genvar ch;
	generate
		for (ch = 0; ch < 16; ch++) begin : g_chan
			drs_pkg::drs_mode_t mode;
			logic               powered;
			logic               useCalPin;

			// reserved code falls back to normal: exactly one mode at a time
			assign mode      = (modeReg[2*ch +: 2] == drs_pkg::DRS_MODE_RSVD) ?
				drs_pkg::DRS_MODE_NORMAL : drs_pkg::drs_mode_t'(modeReg[2*ch +: 2]);
			assign powered   = vbatReg[ch];
			assign useCalPin = trimPinReg[ch];

			// supplies: programming supply only rides on an enabled battery supply
			always_ff @(posedge clk) begin
				if (srst) begin
					vbatEn[ch] <= 1'b0;
					vppEn[ch]  <= 1'b0;
				end else begin
					vbatEn[ch] <= powered;
					vppEn[ch]  <= powered && vppReg[ch];
				end
			end

			// reset pin: faster than a supply cycle, no discharge wait
			always_ff @(posedge clk) begin
				if (srst) begin
					targetRst[ch] <= 1'b1;
				end else begin
					targetRst[ch] <= rstReg[ch] ~^ rstActiveHigh;
				end
			end

			// unpowered target: release both UART lines
			always_ff @(posedge clk) begin
				if (srst) begin
					targetRxOe_n[ch] <= 1'b1;
					targetTxOe_n[ch] <= 1'b1;
				end else begin
					targetRxOe_n[ch] <= !powered;
					targetTxOe_n[ch] <= 1'b1;
				end
			end

			// dedicated calibration output, only for a powered channel in trim mode
			always_ff @(posedge clk) begin
				if (srst) begin
					calPulse[ch] <= 1'b0;
				end else begin
					calPulse[ch] <= powered && (mode == drs_pkg::DRS_MODE_TRIM) &&
						useCalPin && trimBus.pulse;
				end
			end

			// UART routing; host receive idles high while the target is unpowered, except in loopback mode
			always_ff @(posedge clk) begin
				if (srst) begin
					targetRx[ch] <= 1'b1;
					hostRx[ch]   <= 1'b1;
				end else begin
					unique case (mode)
						drs_pkg::DRS_MODE_NORMAL: begin
							targetRx[ch] <= hostTxSync[ch];
							hostRx[ch]   <= powered ? targetTxSync[ch] : 1'b1;
						end
						drs_pkg::DRS_MODE_TRIM: begin
							// receive pin held low as a plain input unless pulse rides on it
							targetRx[ch] <= !useCalPin && trimBus.pulse;
							hostRx[ch]   <= powered ? targetTxSync[ch] : 1'b1;
						end
						drs_pkg::DRS_MODE_LOOP: begin
							targetRx[ch] <= 1'b1;
							hostRx[ch]   <= hostTxSync[ch];
						end
						default: begin
							targetRx[ch] <= 1'b1;
							hostRx[ch]   <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate
endmodule : drs_uart_route_switch

// >>> test/drs_route_checker.sv
`timescale 1ns/1ps
// ==========
// port checks of the route switch
module drs_route_checker #(
	parameter int unsigned TRIM_SHORT_CYC = 30,
	parameter int unsigned TRIM_LONG_CYC  = 50
) (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [7:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic [15:0] hostRx,
	input wire logic [15:0] targetRxOe_n,
	input wire logic [15:0] calPulse,
	input wire logic [15:0] vbatEn,
	input wire logic [15:0] vppEn,
	input wire logic [15:0] targetRst
);
	int unsigned hiCnt;
	logic [31:0] modeShadow;
	logic [15:0] loopMask;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// length is judged at the fall, so a pulse cut short shows up
	always_ff @(posedge clk) begin
		hiCnt <= calPulse[0] ? hiCnt + 1 : 0;
	end
	// mirror of the mode word; the mask lags one edge to line up with hostRx
	always_ff @(posedge clk) begin
		if (srst) begin
			modeShadow <= 32'h0;
			loopMask   <= 16'h0;
		end else begin
			if (regWr && regAddr == 8'h00) begin
				modeShadow <= regWdata;
			end
			for (int i = 0; i < 16; i++) begin
				loopMask[i] <= (modeShadow[2*i +: 2] == 2'h3);
			end
		end
	end
	a_vpp_needs_vbat: assert property ((vppEn & ~vbatEn) == 16'h0)
		else $error("vpp on without vbat");
	a_oe_follows_vbat: assert property (targetRxOe_n == ~vbatEn)
		else $error("rx enable differs from vbat");
	a_hostrx_idle_off: assert property ((hostRx | vbatEn | loopMask) == 16'hffff)
		else $error("host rx not idle while off");
	a_rdata_only_after: assert property (!$past(regRd) |-> regRdata == 32'h0)
		else $error("read data outside its cycle");
	a_vbat_write_applied: assert property (regWr && regAddr == 8'h04 |-> ##2
		vbatEn == $past(regWdata[15:0], 2)) else $error("vbat not as written");
	a_rst_polarity_out: assert property (regWr && regAddr == 8'h08 |-> ##2
		targetRst == ($past(regWdata[15:0], 2) ^ {16{~$past(regWdata[16], 2)}}))
		else $error("target reset wrong");
	a_trim_pulse_len: assert property ($fell(calPulse[0]) |->
		hiCnt == TRIM_SHORT_CYC || hiCnt == TRIM_LONG_CYC) else $error("pulse length");
endmodule : drs_route_checker

bind drs_uart_route_switch drs_route_checker #(
	.TRIM_SHORT_CYC(TRIM_SHORT_CYC),
	.TRIM_LONG_CYC(TRIM_LONG_CYC)
) chk_u (
	.clk          (clk),
	.srst         (srst),
	.regAddr      (regAddr),
	.regWdata     (regWdata),
	.regWr        (regWr),
	.regRd        (regRd),
	.regRdata     (regRdata),
	.hostRx       (hostRx),
	.targetRxOe_n (targetRxOe_n),
	.calPulse     (calPulse),
	.vbatEn       (vbatEn),
	.vppEn        (vppEn),
	.targetRst    (targetRst)
);

// >>> test/drs_target_model.sv
`timescale 1ns/1ps
// ==========
// targets: transmit only while powered
module drs_target_model (
	input  wire logic        clk,
	input  wire logic [15:0] vbatEn,
	input  wire logic [15:0] txData,
	output logic      [15:0] targetTx = 16'h0
);
	// an unpowered target holds no level, so toggle to keep stale values out
	always_ff @(posedge clk) begin
		targetTx <= (txData & vbatEn) | (~targetTx & ~vbatEn);
	end
endmodule : drs_target_model

// >>> test/drs_uart_route_switch_tb_top.sv
`timescale 1ns/1ps
module drs_uart_route_switch_tb_top;
	localparam int unsigned SC = 30;
	localparam int unsigned LC = 50;
	logic clk = 0, srst = 1, regWr = 0, regRd = 0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, rd, r, rng = 32'h46;
	logic [15:0] hostTx = 16'hffff, tgtData = 16'hffff, v, targetTx, hostRx, targetRx;
	logic [15:0] rxOe_n, txOe_n, calPulse, vbatEn, vppEn, targetRst;
	int fails = 0, num_checks = 0, n;
	always #50 clk = ~clk;
	drs_target_model tgt_u (.clk(clk), .vbatEn(vbatEn), .txData(tgtData), .targetTx(targetTx));
	drs_uart_route_switch #(.TRIM_SHORT_CYC(SC), .TRIM_LONG_CYC(LC)) dut_u (.clk(clk),
		.srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .hostTx(hostTx), .hostRx(hostRx), .targetTx(targetTx),
		.targetRx(targetRx), .targetRxOe_n(rxOe_n), .targetTxOe_n(txOe_n), .calPulse(calPulse),
		.vbatEn(vbatEn), .vppEn(vppEn), .targetRst(targetRst));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// spare edge after each access keeps strobes from being set twice at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
		@(posedge clk);
	endtask : rdr
	task automatic final_report();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	// ==========
	// watchdog
	initial begin
		#(100 * 5000);
		fails++;
		final_report();
	end
	// ==========
	// scenarios
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk(targetRst, 16'hffff);
		r = xs();
		v = r[15:0] | 16'h0001;
		wr(8'h04, {r[31:16], v});
		#1;
		chk(vppEn, v & r[31:16]);
		rdr(8'h04, rd);
		chk(rd, {r[31:16], v});
		rdr(8'h14, rd);
		chk(rd, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, {16{m[1:0]}});
			r = xs();
			hostTx <= r[15:0];
			tgtData <= r[31:16];
			repeat (4) @(posedge clk);
			#1;
			chk(rxOe_n, 16'(~v));
			chk(txOe_n, 16'hffff);
			chk(hostRx, 16'(m == 3 ? r[15:0] : ~v | r[31:16]));
			chk(targetRx & v, (m == 3 ? 16'hffff : m == 1 ? 16'h0 : r[15:0]) & v);
			@(posedge clk);
		end
		for (int p = 0; p < 2; p++) begin
			r = xs();
			wr(8'h08, {15'h0, p[0], r[15:0]});
			#1;
			chk(targetRst, 16'(p ? r[15:0] : ~r[15:0]));
		end
		wr(8'h00, 32'h5555_5555);
		for (int l = 0; l < 2; l++) begin
			wr(8'h10, l ? 32'hffff : 32'h0);
			wr(8'h0c, {30'h0, l[0], 1'b1});
			n = 0;
			// first sample lands just after the edge that raises the pin
			for (int i = 0; i < 200; i++) begin
				#1;
				if ((l ? calPulse[0] : targetRx[0]) === 1'b1) n++;
				@(posedge clk);
			end
			chk(n, l ? LC : SC);
		end
		// short mid-run reset pulse: every switch back to its safe state
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		chk(vbatEn, 16'h0);
		chk(targetRst, 16'hffff);
		rdr(8'h04, rd);
		chk(rd, 32'h0);
		final_report();
	end
endmodule : drs_uart_route_switch_tb_top
